// ### pfc_pkg.sv
// Constants, field layouts and types for the synthesizer control-word bank.
// Assumes 24-bit serial words, data above four select bits, MSB shifted first.
package pfc_pkg;

  // ==========================================================================
  // Serial word layout
  localparam int unsigned WORD_W   = 24;
  localparam int unsigned SEL_W    = 4;
  localparam int unsigned CNT_W    = 5;
  localparam logic [3:0]  SEL_AUX_MAIN  = 4'h3;
  localparam logic [3:0]  SEL_REF_GAIN  = 4'h5;
  localparam logic [3:0]  SEL_FASTLOCK  = 4'h7;
  localparam logic [3:0]  SEL_PUMP_CTL  = 4'hB;

  // ==========================================================================
  // Field positions
  localparam int unsigned AUX_PD_BIT    = 23;
  localparam int unsigned AUX_PRESC_BIT = 22;
  localparam int unsigned AUX_GAIN_BIT  = 21;
  localparam int unsigned AUX_TRI_BIT   = 16;
  localparam int unsigned REF_ZERO_BIT  = 23;
  localparam int unsigned GAIN_HI       = 22;
  localparam int unsigned GAIN_LO       = 19;
  localparam int unsigned REF_HI        = 18;
  localparam int unsigned REF_LO        = 4;
  localparam int unsigned CSR_HI        = 23;
  localparam int unsigned CSR_LO        = 22;
  localparam int unsigned CPF_HI        = 21;
  localparam int unsigned CPF_LO        = 18;
  localparam int unsigned TOC_HI        = 17;
  localparam int unsigned TOC_LO        = 4;

  // ==========================================================================
  // Timeout codes and reset values
  localparam logic [13:0] TOC_FLOAT     = 14'h0000;
  localparam logic [13:0] TOC_MANUAL    = 14'h0001;
  localparam logic [13:0] TOC_LOW       = 14'h0002;
  localparam logic [13:0] TOC_HIGH      = 14'h0003;
  localparam logic [13:0] TOC_TIMED_MIN = 14'h0004;
  localparam logic [14:0] EVT_ONE       = 15'h0001;
  localparam logic [CNT_W-1:0] BIT_ONE  = 5'h01;
  localparam logic [14:0] REF_RST       = 15'h0003;
  localparam logic [3:0]  CODE_RST      = 4'h0;
  localparam logic [1:0]  CSR_OFF       = 2'h0;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    PFC_FL_IDLE   = 2'b00,
    PFC_FL_TIMED  = 2'b01,
    PFC_FL_MANUAL = 2'b11
  } pfc_fl_state_type;

  typedef struct packed {
    logic        pump_gain_sel;
    logic        presc_sel;
    logic        powerdown;
    logic        pump_tristate_ctl;
    logic [14:0] ref_div;
  } pfc_aux_cfg_type;

  typedef struct packed {
    logic [3:0]  pump_gain;
    logic [1:0]  cycle_slip_reduction;
    logic [3:0]  fastlock_pump_current;
    logic [13:0] fastlock_timeout;
  } pfc_main_cfg_type;

endpackage

// ### pfc_pll_divider_fastlock_config.sv
// Serially loaded control-word bank: auxiliary loop setup, main loop pump
// gain and the main loop fast-lock timeout counter with its pin.
// Assumes the host keeps the serial clock still while load enable is high,
// and that the comparison tick and pump-phase inputs are asynchronous levels.
`timescale 1ns/10ps
module pfc_pll_divider_fastlock_config
  import pfc_pkg::*;
#(
  parameter int unsigned TOC_W = 14
) (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        ce_in,
  input  wire logic        ser_clk_in,
  input  wire logic        ser_data_in,
  input  wire logic        ser_le_in,
  input  wire logic        cmp_tick_in,
  input  wire logic        aux_pump_on_in,
  output logic             aux_pump_gain_sel_out,
  output logic             aux_presc_sel_out,
  output logic             aux_powerdown_out,
  output logic [14:0]      aux_ref_div_out,
  output logic [3:0]       main_pump_code_out,
  output logic [1:0]       cycle_slip_reduction_out,
  output logic             main_fastlock_active_out,
  output logic             main_fastlock_pin_out,
  output logic             main_fastlock_pin_oe_out
);

  if (TOC_W != 14) begin : g_chk
    $error("TOC_W must be 14");
  end

  // ==========================================================================
  // Link domain: shifter and edge toggle only, no count.
  // Counting happens on clk_in so the count can be cleared with no link edge.
  logic [WORD_W-1:0] shift_q;
  logic              edge_tgl_q;

  always_ff @(posedge ser_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shift_q <= '0;
    end else begin
      shift_q <= {shift_q[WORD_W-2:0], ser_data_in};
    end
  end

  always_ff @(posedge ser_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      edge_tgl_q <= 1'b0;
    end else begin
      edge_tgl_q <= ~edge_tgl_q;
    end
  end

  // ==========================================================================
  // Synchronisers
  // Toggle crossing: each link edge flips one level, none lost
  // while link edges stay over one clk_in period apart.
  // Raw inputs meet only the first stage; logic reads the second.
  logic [1:0] tgl_sync_q;
  logic [1:0] le_sync_q;
  logic [1:0] tick_sync_q;
  logic [1:0] pump_sync_q;
  logic       tgl_seen_q;
  logic       le_seen_q;
  logic       tick_seen_q;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tgl_sync_q  <= '0;
      le_sync_q   <= '0;
      tick_sync_q <= '0;
      pump_sync_q <= '0;
      tgl_seen_q  <= 1'b0;
      le_seen_q   <= 1'b0;
      tick_seen_q <= 1'b0;
    end else if (ce_in) begin
      tgl_sync_q  <= {tgl_sync_q[0], edge_tgl_q};
      le_sync_q   <= {le_sync_q[0], ser_le_in};
      tick_sync_q <= {tick_sync_q[0], cmp_tick_in};
      pump_sync_q <= {pump_sync_q[0], aux_pump_on_in};
      tgl_seen_q  <= tgl_sync_q[1];
      le_seen_q   <= le_sync_q[1];
      tick_seen_q <= tick_sync_q[1];
    end
  end

  logic bit_evt;
  logic le_rise;
  logic pump_evt;
  assign bit_evt  = tgl_sync_q[1] ^ tgl_seen_q;
  assign le_rise  = le_sync_q[1] & ~le_seen_q;
  assign pump_evt = tick_sync_q[1] & ~tick_seen_q;

  // ==========================================================================
  // Bit count and load
  logic [CNT_W-1:0] bit_cnt_q;
  logic             word_ok;
  logic             load;
  logic [SEL_W-1:0] sel;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bit_cnt_q <= '0;
    end else if (ce_in) begin
      if (le_sync_q[1]) begin
        bit_cnt_q <= '0;
      end else if (bit_evt && bit_cnt_q != CNT_W'(WORD_W)) begin
        bit_cnt_q <= bit_cnt_q + BIT_ONE;
      end
    end
  end

  // Shifter is quiet while load enable is high, so the word is stable here
  assign word_ok = (bit_cnt_q == CNT_W'(WORD_W));
  assign load    = le_rise & word_ok;
  assign sel     = shift_q[SEL_W-1:0];

  // ==========================================================================
  // Control words
  pfc_aux_cfg_type  aux_q;
  pfc_main_cfg_type main_q;
  logic             toc_load_q;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aux_q <= '{1'b0, 1'b0, 1'b0, 1'b0, REF_RST};
    end else if (ce_in && load) begin
      if (sel == SEL_AUX_MAIN) begin
        aux_q.pump_gain_sel <= shift_q[AUX_GAIN_BIT];
        aux_q.presc_sel     <= shift_q[AUX_PRESC_BIT];
        aux_q.powerdown     <= shift_q[AUX_PD_BIT];
      end else if (sel == SEL_REF_GAIN) begin
        aux_q.ref_div <= shift_q[REF_HI:REF_LO];
      end else if (sel == SEL_PUMP_CTL) begin
        aux_q.pump_tristate_ctl <= shift_q[AUX_TRI_BIT];
      end
    end
  end

  // Bit REF_ZERO_BIT of the ref-divider word is ignored, as it must be zero
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      main_q <= '{CODE_RST, CSR_OFF, CODE_RST, TOC_FLOAT};
    end else if (ce_in && load) begin
      if (sel == SEL_REF_GAIN) begin
        main_q.pump_gain <= shift_q[GAIN_HI:GAIN_LO];
      end else if (sel == SEL_FASTLOCK) begin
        main_q.cycle_slip_reduction  <= shift_q[CSR_HI:CSR_LO];
        main_q.fastlock_pump_current <= shift_q[CPF_HI:CPF_LO];
        main_q.fastlock_timeout      <= shift_q[TOC_HI:TOC_LO];
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      toc_load_q <= 1'b0;
    end else if (ce_in) begin
      toc_load_q <= load && (sel == SEL_FASTLOCK);
    end
  end

  // ==========================================================================
  // Fast-lock timer, counted in comparison ticks
  // Timeout decode, shared by the timer and the pin logic
  function automatic logic toc_is_timed(input logic [TOC_W-1:0] toc);
    return (toc >= TOC_TIMED_MIN);
  endfunction

  pfc_fl_state_type fl_state_q;
  logic [TOC_W:0]   evt_left_q;
  logic             timed;

  assign timed = toc_is_timed(main_q.fastlock_timeout);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fl_state_q <= PFC_FL_IDLE;
      evt_left_q <= '0;
    end else if (ce_in) begin
      // A fresh fast-lock word restarts the timer, even mid-period
      if (toc_load_q) begin
        if (main_q.fastlock_timeout == TOC_MANUAL) begin
          fl_state_q <= PFC_FL_MANUAL;
        end else if (timed) begin
          fl_state_q <= PFC_FL_TIMED;
          evt_left_q <= {main_q.fastlock_timeout, 1'b0};
        end else begin
          fl_state_q <= PFC_FL_IDLE;
        end
      end else begin
        case (fl_state_q)
          PFC_FL_TIMED: begin
            if (pump_evt) begin
              if (evt_left_q == EVT_ONE) begin
                fl_state_q <= PFC_FL_IDLE;
              end
              evt_left_q <= evt_left_q - EVT_ONE;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Outputs
  // Pin decode follows the timeout the timer took, so pin, enable
  // and active status all move on one edge
  logic [TOC_W-1:0] toc_cur_q;
  logic             cur_timed;
  logic             fl_on;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      toc_cur_q <= TOC_FLOAT;
    end else if (ce_in && toc_load_q) begin
      toc_cur_q <= main_q.fastlock_timeout;
    end
  end

  assign cur_timed = toc_is_timed(toc_cur_q);
  assign fl_on = (fl_state_q != PFC_FL_IDLE);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      main_pump_code_out       <= CODE_RST;
      cycle_slip_reduction_out <= CSR_OFF;
      main_fastlock_active_out <= 1'b0;
    end else if (ce_in) begin
      main_fastlock_active_out <= fl_on;
      if (fl_on) begin
        main_pump_code_out       <= main_q.fastlock_pump_current;
        cycle_slip_reduction_out <= main_q.cycle_slip_reduction;
      end else begin
        main_pump_code_out       <= main_q.pump_gain;
        cycle_slip_reduction_out <= CSR_OFF;
      end
    end
  end

  // Timed mode pin: low while fast-lock runs, high once it has ended
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      main_fastlock_pin_out    <= 1'b0;
      main_fastlock_pin_oe_out <= 1'b0;
    end else if (ce_in) begin
      main_fastlock_pin_oe_out <= (toc_cur_q != TOC_FLOAT);
      if (toc_cur_q == TOC_HIGH) begin
        main_fastlock_pin_out <= 1'b1;
      end else if (cur_timed) begin
        main_fastlock_pin_out <= (fl_state_q != PFC_FL_TIMED);
      end else begin
        main_fastlock_pin_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aux_pump_gain_sel_out <= 1'b0;
      aux_presc_sel_out     <= 1'b0;
      aux_powerdown_out     <= 1'b0;
      aux_ref_div_out       <= REF_RST;
    end else if (ce_in) begin
      aux_pump_gain_sel_out <= aux_q.pump_gain_sel;
      aux_presc_sel_out     <= aux_q.presc_sel;
      aux_ref_div_out       <= aux_q.ref_div;
      if (!aux_q.powerdown) begin
        aux_powerdown_out <= 1'b0;
      end else if (aux_q.pump_tristate_ctl) begin
        aux_powerdown_out <= 1'b1;
      end else if (!pump_sync_q[1]) begin
        aux_powerdown_out <= 1'b1;
      end
    end
  end

endmodule

// ### pfc_host_model.sv
// Host model: writes control words over the three-wire serial port.
// Assumes one caller at a time, each word finished before the next.
`timescale 1ns/10ps
module pfc_host_model (
  output logic ser_clk_out,
  output logic ser_data_out,
  output logic ser_le_out
);
  // ==========
  // Idle: clock still, load enable high
  initial begin
    ser_clk_out  = 1'b0;
    ser_data_out = 1'b0;
    ser_le_out   = 1'b1;
  end

  // MSB first; n below 24 gives a cut-short frame
  task automatic send(input logic [23:0] w, input int n);
    ser_le_out = 1'b0;
    #200;
    for (int i = 23; i > 23 - n; i--) begin
      ser_data_out = w[i];
      #62.5 ser_clk_out = 1'b1;
      #62.5 ser_clk_out = 1'b0;
    end
    // Released line must not show the last bit
    ser_data_out = ~ser_data_out;
    #100 ser_le_out = 1'b1;
    #200;
  endtask
endmodule

// ### pfc_cfg_assertions.sv
// Checker on the control-word bank ports, clk_in domain.
// Assumes it is bound to the bank's top module.
`timescale 1ns/10ps
module pfc_cfg_assertions
  import pfc_pkg::*;
#(
  parameter int unsigned TOC_W = 14
) (
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  input wire logic        ser_le_in,
  input wire logic        aux_pump_on_in,
  input wire logic        aux_pump_gain_sel_out,
  input wire logic        aux_presc_sel_out,
  input wire logic        aux_powerdown_out,
  input wire logic [14:0] aux_ref_div_out,
  input wire logic [1:0]  cycle_slip_reduction_out,
  input wire logic        main_fastlock_active_out,
  input wire logic        main_fastlock_pin_out,
  input wire logic        main_fastlock_pin_oe_out
);
  // ==========
  // Properties
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  // Long enough that any load has fully landed
  sequence le_quiet;
    (!ser_le_in)[*8];
  endsequence

  chk_float_idle: assert property (!main_fastlock_pin_oe_out |->
    !main_fastlock_active_out && !main_fastlock_pin_out) else $error("floating pin while active");
  chk_active_pin: assert property (main_fastlock_active_out |->
    main_fastlock_pin_oe_out && !main_fastlock_pin_out) else $error("pin not low in fast-lock");
  chk_csr_idle: assert property (!main_fastlock_active_out |->
    cycle_slip_reduction_out == CSR_OFF) else $error("cycle slip on outside fast-lock");
  chk_quiet_cfg: assert property (le_quiet |-> $stable({aux_ref_div_out,
    aux_pump_gain_sel_out, aux_presc_sel_out})) else $error("config moved without a load");
  chk_fastlock_min: assert property ($rose(main_fastlock_active_out) |->
    main_fastlock_active_out[*8]) else $error("fast-lock ended too soon");
  chk_timed_end: assert property (le_quiet ##0 $fell(main_fastlock_active_out) |->
    ##[0:1] (main_fastlock_pin_out && main_fastlock_pin_oe_out)) else $error("pin not high");
  chk_pd_waits: assert property (le_quiet ##0 $past(aux_pump_on_in, 2) &&
    $past(aux_pump_on_in, 3) && $past(aux_pump_on_in, 4) |-> !$rose(aux_powerdown_out))
    else $error("power-down while pump on");
  chk_pd_release: assert property (le_quiet |-> !$fell(aux_powerdown_out))
    else $error("power-down released without a load");
endmodule

bind pfc_pll_divider_fastlock_config pfc_cfg_assertions #(.TOC_W(TOC_W)) u_chk (
  .clk_in, .reset_n_in, .ser_le_in, .aux_pump_on_in, .aux_pump_gain_sel_out,
  .aux_presc_sel_out, .aux_powerdown_out, .aux_ref_div_out, .cycle_slip_reduction_out,
  .main_fastlock_active_out, .main_fastlock_pin_out, .main_fastlock_pin_oe_out);

// ### pfc_pll_divider_fastlock_config_tb.sv
// Self-checking bench for the control-word bank.
// Assumes the package, host model and checker are compiled first.
`timescale 1ns/10ps
module pfc_pll_divider_fastlock_config_tb;
  import pfc_pkg::*;
  typedef struct packed {logic [23:0] w; logic [26:0] e;} pfc_row_type;
  localparam logic [23:0] QT = {15'h0003, 4'h6, 2'h0, 3'b011};
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        ce_in = 1'b1;
  logic        cmp_tick_in = 1'b0;
  logic        aux_pump_on_in = 1'b0;
  wire logic   ser_clk, ser_data, ser_le;
  wire logic [26:0] obs;
  int          miscompares = 0;
  int          samples_checked = 0;
  pfc_row_type rows [7] = '{
    '{24'h200003, {3'b100, 15'h0003, 4'h0, 2'h0, 3'b000}},
    '{24'h400003, {3'b010, 15'h0003, 4'h0, 2'h0, 3'b000}},
    '{24'hFFFFF5, {3'b010, 15'h7FFF, 4'hF, 2'h0, 3'b000}},
    '{24'h300035, {3'b010, 15'h0003, 4'h6, 2'h0, 3'b000}},
    '{24'hFC0027, {3'b010, 15'h0003, 4'h6, 2'h0, 3'b001}},
    '{24'hFC0037, {3'b010, 15'h0003, 4'h6, 2'h0, 3'b011}},
    '{24'hFC0007, {3'b010, 15'h0003, 4'h6, 2'h0, 3'b000}}};

  always #25 clk_in = ~clk_in;

  pfc_host_model u_host (.ser_clk_out(ser_clk), .ser_data_out(ser_data), .ser_le_out(ser_le));

  pfc_pll_divider_fastlock_config #(.TOC_W(14)) dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in), .ser_clk_in(ser_clk),
    .ser_data_in(ser_data), .ser_le_in(ser_le), .cmp_tick_in(cmp_tick_in),
    .aux_pump_on_in(aux_pump_on_in), .aux_pump_gain_sel_out(obs[26]),
    .aux_presc_sel_out(obs[25]), .aux_powerdown_out(obs[24]), .aux_ref_div_out(obs[23:9]),
    .main_pump_code_out(obs[8:5]), .cycle_slip_reduction_out(obs[4:3]),
    .main_fastlock_active_out(obs[2]), .main_fastlock_pin_out(obs[1]),
    .main_fastlock_pin_oe_out(obs[0]));

  // ==========
  // Tasks
  task automatic check(input string what, input logic [26:0] e);
    samples_checked++;
    if (obs !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, e, obs);
    end
  endtask

  task automatic wr(input logic [23:0] w, input int n);
    u_host.send(w, n);
    repeat (10) @(posedge clk_in);
  endtask

  // Ticks spaced eleven cycles, high for two, above the synchroniser's minimum
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_in) cmp_tick_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      cmp_tick_in <= 1'b0;
      repeat (8) @(posedge clk_in);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========
  // Sequence
  initial begin
    #2000000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    check("reset", {3'b000, 15'h0003, 4'h0, 2'h0, 3'b000});
    foreach (rows[i]) begin
      wr(rows[i].w, 24);
      check("row", rows[i].e);
    end
    wr(24'h940017, 24);
    tick(3);
    check("manual", {3'b010, 15'h0003, 4'h5, 2'h2, 3'b101});
    wr(24'hE40047, 24);
    tick(7);
    check("timed", {3'b010, 15'h0003, 4'h9, 2'h3, 3'b101});
    // Last tick lands mid-frame, so the end is seen with load enable low
    fork
      begin
        repeat (12) @(posedge clk_in);
        tick(1);
      end
      wr(24'h300105, 20);
    join
    check("timed end", {3'b010, QT});
    check("short", {3'b010, QT});
    wr(24'h00000B, 24);
    aux_pump_on_in <= 1'b1;
    wr(24'hC00003, 24);
    check("pd wait", {3'b010, QT});
    aux_pump_on_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    check("pd off", {3'b011, QT});
    wr(24'h400003, 24);
    check("pd release", {3'b010, QT});
    wr(24'h01000B, 24);
    aux_pump_on_in <= 1'b1;
    wr(24'hC00003, 24);
    check("pd now", {3'b011, QT});
    ce_in <= 1'b0;
    wr(24'h200003, 24);
    check("ce hold", {3'b011, QT});
    ce_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    check("ce resume", {3'b011, QT});
    tally_and_finish();
  end
endmodule
